// file: dv/usart_sync_slave_sleep_bench.sv
module usart_sync_slave_sleep_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i, rstn_i, psel, penable, pwrite, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, sck, msdo, dout, doe, irq, wake, vec, line;
  logic [8:0] w;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  assign line = doe ? dout : msdo;
  ussl_top #(.RX_DEPTH(2)) u_dut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .serial_clock_pin_i(sck),
    .serial_data_pin_i(line), .serial_data_pin_o(dout),
    .serial_data_pin_oe_o(doe), .irq_o(irq), .wake_o(wake), .vector_o(vec)
  );
  ussl_link_model u_link (.sck_o(sck), .sdo_o(msdo), .line_i(line));
  initial begin
    mclk_i = 1'h0;
    forever #50 mclk_i = ~mclk_i;
  end
  // Whole run is well under a thousand cycles; this only cuts a hang
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'h1;
    // Answer looked at and taken mid-cycle; bus released at the following rising edge
    do begin
      @(negedge mclk_i);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      bad_count++;
    end
    q = prdata;
    err = pslverr;
    @(posedge mclk_i);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 200) begin
      @(negedge mclk_i);
      n++;
    end
    check({31'h0, irq}, {31'h0, v});
  endtask : wait_irq
  task automatic t_regs;
    apb(1'h0, ussl_pkg::USSL_RXSTAT_OFS, 32'h0);
    check(q, {24'h0, ussl_pkg::USSL_RS_RESET});
    apb(1'h0, ussl_pkg::USSL_TXSTAT_OFS, 32'h0);
    check(q, {24'h0, ussl_pkg::USSL_TS_RESET});
    apb(1'h1, ussl_pkg::USSL_RXDATA_OFS, 32'h55);
    check({31'h0, err}, 32'h1);
    apb(1'h0, 8'h28, 32'h0);
    check({err, q[30:0]}, 32'h80000000);
    $display("done: regs");
  endtask : t_regs
  task automatic t_rx8;
    apb(1'h1, ussl_pkg::USSL_TXSTAT_OFS, 32'h10); // slave, sync
    apb(1'h1, ussl_pkg::USSL_RXSTAT_OFS, 32'hB0); // single rx too
    apb(1'h1, ussl_pkg::USSL_IRQMASK_OFS, 32'h1);
    apb(1'h1, ussl_pkg::USSL_CORECTL_OFS, 32'h5); // peripheral enable, sleep
    u_link.send(9'h0A5, 8);
    wait_irq(1'h1);
    check({30'h0, wake, vec}, 32'h2);
    apb(1'h0, ussl_pkg::USSL_IRQSTAT_OFS, 32'h0);
    check(q & 32'h9, 32'h9);
    apb(1'h1, ussl_pkg::USSL_IRQMASK_OFS, 32'h0);
    wait_irq(1'h0);
    apb(1'h1, ussl_pkg::USSL_IRQMASK_OFS, 32'h1);
    wait_irq(1'h1);
    apb(1'h0, ussl_pkg::USSL_RXDATA_OFS, 32'h0);
    check(q, 32'hA5);
    wait_irq(1'h0);
    apb(1'h1, ussl_pkg::USSL_IRQSTAT_OFS, 32'h1);
    apb(1'h0, ussl_pkg::USSL_IRQSTAT_OFS, 32'h0);
    check(q & 32'h1, 32'h0);
    $display("done: rx8");
  endtask : t_rx8
  task automatic t_rx9;
    apb(1'h1, ussl_pkg::USSL_CORECTL_OFS, 32'h3);
    apb(1'h1, ussl_pkg::USSL_RXSTAT_OFS, 32'hD0);
    u_link.send(9'h1C3, 9);
    wait_irq(1'h1);
    check({31'h0, vec}, 32'h1);
    apb(1'h0, ussl_pkg::USSL_RXSTAT_OFS, 32'h0); // ninth first
    check(q, 32'hD1);
    apb(1'h0, ussl_pkg::USSL_RXDATA_OFS, 32'h0);
    check(q, 32'hC3);
    $display("done: rx9");
  endtask : t_rx9
  task automatic t_overrun;
    apb(1'h1, ussl_pkg::USSL_RXSTAT_OFS, 32'h90);
    for (int i = 0; i < 3; i++) begin
      u_link.send(9'h011 << i, 8);
    end
    // Push lands a few cycles after the last rising clock
    repeat (8) @(posedge mclk_i);
    apb(1'h0, ussl_pkg::USSL_RXDATA_OFS, 32'h0);
    check(q, 32'h11);
    apb(1'h0, ussl_pkg::USSL_RXSTAT_OFS, 32'h0);
    check(q & 32'h2, 32'h2);
    apb(1'h0, ussl_pkg::USSL_IRQSTAT_OFS, 32'h0);
    check(q & 32'h4, 32'h4);
    apb(1'h1, ussl_pkg::USSL_RXSTAT_OFS, 32'h80);
    apb(1'h0, ussl_pkg::USSL_RXSTAT_OFS, 32'h0);
    check(q & 32'h2, 32'h0);
    wait_irq(1'h1);
    apb(1'h1, ussl_pkg::USSL_RXSTAT_OFS, 32'h0);
    wait_irq(1'h0);
    apb(1'h1, ussl_pkg::USSL_IRQSTAT_OFS, 32'h7);
    $display("done: overrun");
  endtask : t_overrun
  task automatic t_tx;
    apb(1'h1, ussl_pkg::USSL_RXSTAT_OFS, 32'h80);
    apb(1'h1, ussl_pkg::USSL_TXSTAT_OFS, 32'h30);
    apb(1'h1, ussl_pkg::USSL_IRQMASK_OFS, 32'h2);
    apb(1'h1, ussl_pkg::USSL_CORECTL_OFS, 32'h5);
    wait_irq(1'h1);
    apb(1'h1, ussl_pkg::USSL_TXDATA_OFS, 32'h5A);
    apb(1'h1, ussl_pkg::USSL_TXDATA_OFS, 32'h3C);
    wait_irq(1'h0);
    u_link.take(w, 8);
    check({23'h0, w}, 32'h5A);
    wait_irq(1'h1);
    check({31'h0, wake}, 32'h1);
    u_link.take(w, 8);
    check({23'h0, w}, 32'h3C);
    apb(1'h1, ussl_pkg::USSL_RXSTAT_OFS, 32'h0);
    $display("done: tx");
  endtask : t_tx
  task automatic tally_and_finish;
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    rstn_i = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'h1;
    t_regs();
    t_rx8();
    t_rx9();
    t_overrun();
    t_tx();
    tally_and_finish();
  end
endmodule : usart_sync_slave_sleep_bench

// file: dv/ussl_link_model.sv
module ussl_link_model (
  output logic sck_o,
  output logic sdo_o,
  input wire logic line_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // Clock stands low between frames; this side owns it
  initial begin
    sck_o = 1'h0;
    sdo_o = 1'h0;
  end
  // Data set in the low phase, held across the rising edge
  task automatic send(input logic [8:0] w, input int n);
    #37;
    for (int i = 0; i < n; i++) begin
      sdo_o = w[i];
      #400 sck_o = 1'h1;
      #400 sck_o = 1'h0;
    end
    // Released line must not mimic the last bit
    sdo_o = ~sdo_o;
  endtask : send
  // Sampled late in the high phase, long after the device moved it
  task automatic take(output logic [8:0] w, input int n);
    w = 9'h000;
    #37;
    for (int i = 0; i < n; i++) begin
      #400 sck_o = 1'h1;
      #390 w[i] = line_i;
      #10 sck_o = 1'h0;
    end
  endtask : take
endmodule : ussl_link_model

// file: dv/ussl_top_checker.sv
module ussl_top_checker (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic serial_clock_pin_i,
  input wire logic serial_data_pin_o,
  input wire logic serial_data_pin_oe_o,
  input wire logic irq_o,
  input wire logic wake_o,
  input wire logic vector_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic apb_wr;
  assign apb_wr = psel_i && pwrite_i;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  AST_PREADY_NEXT:
    assert property (psel_i && !penable_i |=> pready_o)
    else $error("pready missing in access cycle");
  AST_PREADY_ONCE:
    assert property (pready_o |=> !pready_o)
    else $error("pready held too long");
  AST_SLVERR_QUAL:
    assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  AST_RDATA_BYTE:
    assert property (pready_o |-> prdata_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_WAKE_IRQ:
    assert property (wake_o |-> irq_o)
    else $error("wake without interrupt cause");
  AST_VECTOR_IRQ:
    assert property (vector_o |-> irq_o)
    else $error("vector without interrupt cause");
  AST_OE_BY_WRITE:
    assert property ($fell(serial_data_pin_oe_o) |->
      $past(apb_wr, 1) || $past(apb_wr, 2) || $past(apb_wr, 3))
    else $error("data pin released without a register write");
  AST_TX_HOLD:
    assert property (serial_data_pin_oe_o && $past(serial_data_pin_oe_o)
      && $changed(serial_data_pin_o) |-> !$past(serial_clock_pin_i, 2))
    else $error("data out moved while clock high");
endmodule : ussl_top_checker
bind ussl_top ussl_top_checker u_chk (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .serial_clock_pin_i(serial_clock_pin_i),
  .serial_data_pin_o(serial_data_pin_o),
  .serial_data_pin_oe_o(serial_data_pin_oe_o), .irq_o(irq_o),
  .wake_o(wake_o), .vector_o(vector_o)
);

// file: hw/ussl_pkg.sv
// Functional notes
// - Nine-bit receive enable shifts nine bits; ninth kept for oldest character.
// - Slave reception runs only while continuous receive enable is set.
// - Receive flag sets on a complete character; interrupt only if enabled.
// - Reading receive data returns oldest low byte and pops it.
// - Overrun latches until continuous receive or port enable clears; port off resets.
// - Only slave mode shifts while the system clock sleeps.
// - External master clocks both transmit and receive shift registers.
// - In sleep, data comes from the data pin, clock from the clock pin.
// - Word received in sleep sets receive flag and requests wake.
// - Writing transmit data clears transmit flag and loads shift register or buffer.
// - In sleep, transmit takes clock pin and drives data pin.
// - Last bit out moves pending byte to shifter, sets transmit flag, wakes.
// - Wake continues with next instruction; global enable also vectors to service.
// - Slave receiver idles while continuous receive is clear; single receive enable is ignored.
package ussl_pkg;
  localparam logic [7:0] USSL_BAUD_OFS = 8'h00;
  localparam logic [7:0] USSL_RXDATA_OFS = 8'h04;
  localparam logic [7:0] USSL_RXSTAT_OFS = 8'h08;
  localparam logic [7:0] USSL_DIVLO_OFS = 8'h0C;
  localparam logic [7:0] USSL_DIVHI_OFS = 8'h10;
  localparam logic [7:0] USSL_TXDATA_OFS = 8'h14;
  localparam logic [7:0] USSL_TXSTAT_OFS = 8'h18;
  localparam logic [7:0] USSL_IRQSTAT_OFS = 8'h1C;
  localparam logic [7:0] USSL_IRQMASK_OFS = 8'h20;
  localparam logic [7:0] USSL_CORECTL_OFS = 8'h24;
  // receive_status_control bits
  localparam int USSL_RS_PORTEN = 7;
  localparam int USSL_RS_NINE = 6;
  localparam int USSL_RS_ONCE = 5;
  localparam int USSL_RS_CONT = 4;
  localparam int USSL_RS_OERR = 1;
  localparam int USSL_RS_NINTH = 0;
  // transmit_status_control bits
  localparam int USSL_TS_CKMST = 7;
  localparam int USSL_TS_TX9 = 6;
  localparam int USSL_TS_TXEN = 5;
  localparam int USSL_TS_SYNC = 4;
  localparam int USSL_TS_TRMT = 1;
  localparam int USSL_TS_TX9D = 0;
  // Interrupt status/mask bits
  localparam int USSL_IRQ_RC = 0;
  localparam int USSL_IRQ_TX = 1;
  localparam int USSL_IRQ_OV = 2;
  // core_int_control bits
  localparam int USSL_CC_PERIEN = 0;
  localparam int USSL_CC_GLOBEN = 1;
  localparam int USSL_CC_SLEEP = 2;
  localparam logic [7:0] USSL_RS_RESET = 8'h00;
  localparam logic [7:0] USSL_TS_RESET = 8'h02;
  localparam logic [2:0] USSL_SYNC_LAST = 3'h4;
  localparam logic [3:0] USSL_BITS8 = 4'h8;
  localparam logic [3:0] USSL_BITS9 = 4'h9;
  typedef struct packed {
    logic [8:0] data;
  } ussl_char_t;
  typedef enum logic [1:0] {USSL_IDLE, USSL_SHIFT} ussl_tx_state_t;
endpackage : ussl_pkg

// file: hw/ussl_top.sv
// The APB interface to the registers and the register offsets were left to the implementer.
module ussl_top #(
  parameter int RX_DEPTH = 2
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic serial_clock_pin_i,
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe_o,
  output logic irq_o,
  output logic wake_o,
  output logic vector_o
);
  // Registers
  logic [7:0] rs_r;
  logic [7:0] ts_r;
  logic [7:0] baud_r;
  logic [7:0] divlo_r;
  logic [7:0] divhi_r;
  logic [2:0] ists_r;
  logic [2:0] imask_r;
  logic [2:0] core_r;
  logic port_en;
  logic slave;
  logic cont_rx;
  assign port_en = rs_r[ussl_pkg::USSL_RS_PORTEN];
  assign slave = ts_r[ussl_pkg::USSL_TS_SYNC] &
                 ~ts_r[ussl_pkg::USSL_TS_CKMST] & port_en;
  assign cont_rx = rs_r[ussl_pkg::USSL_RS_CONT];

  // Bus decode
  logic wr_en;
  logic rd_en;
  assign wr_en = psel_i & penable_i & pwrite_i & pready_o;
  assign rd_en = psel_i & penable_i & ~pwrite_i & pready_o;

  // Clock pin: three flops, edge when second and third agree on change
  logic [2:0] ck_sync_r;
  logic ck_state_r;
  logic [2:0] dt_sync_r;
  logic ck_rise;
  logic ck_fall;
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ck_sync_r <= 3'h0;
      dt_sync_r <= 3'h0;
      ck_state_r <= 1'b0;
    end else begin
      ck_sync_r <= {ck_sync_r[1:0], serial_clock_pin_i};
      dt_sync_r <= {dt_sync_r[1:0], serial_data_pin_i};
      if (ck_sync_r[1] == ck_sync_r[2]) begin
        ck_state_r <= ck_sync_r[2];
      end
    end
  end
  assign ck_rise = (ck_sync_r[1] == ck_sync_r[2]) & ck_sync_r[2] &
                   ~ck_state_r;
  assign ck_fall = (ck_sync_r[1] == ck_sync_r[2]) & ~ck_sync_r[2] &
                   ck_state_r;

  // Mode: receive when continuous receive set, else transmit when transmit enabled and single receive clear
  logic rx_mode;
  logic tx_mode;
  // Single receive enable is a don't care for slave receive; when set it blocks transmit
  assign rx_mode = slave & cont_rx;
  assign tx_mode = slave & ~cont_rx & ~rs_r[ussl_pkg::USSL_RS_ONCE] &
                   ts_r[ussl_pkg::USSL_TS_TXEN];

  // Receive shifter, sampled on rising clock edge
  logic [8:0] rx_sh_r;
  logic [3:0] rcnt_r;
  logic [3:0] rbits;
  logic rx_done;
  assign rbits = rs_r[ussl_pkg::USSL_RS_NINE] ? ussl_pkg::USSL_BITS9 :
                 ussl_pkg::USSL_BITS8;
  assign rx_done = rx_mode & ck_rise & (rcnt_r == rbits - 4'h1);
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || !rx_mode) begin
      rx_sh_r <= 9'h000;
      rcnt_r <= 4'h0;
    end else if (ck_rise) begin
      // LSB first; a 9-bit frame's last bit lands in bit 8
      rx_sh_r <= {dt_sync_r[2], rx_sh_r[8:1]};
      rcnt_r <= rx_done ? 4'h0 : rcnt_r + 4'h1;
    end
  end
  logic [8:0] rx_word;
  assign rx_word = rs_r[ussl_pkg::USSL_RS_NINE] ?
                   {dt_sync_r[2], rx_sh_r[8:1]} :
                   {1'b0, dt_sync_r[2], rx_sh_r[8:2]};

  // Receive FIFO
  ussl_pkg::ussl_char_t fifo_r [RX_DEPTH];
  logic [$clog2(RX_DEPTH):0] fcnt_r;
  logic [$clog2(RX_DEPTH)-1:0] rptr_r;
  logic [$clog2(RX_DEPTH)-1:0] wptr_r;
  logic push;
  logic pop;
  logic full;
  logic empty;
  assign full = (fcnt_r == ($clog2(RX_DEPTH)+1)'(RX_DEPTH));
  assign empty = (fcnt_r == '0);
  assign pop = rd_en & (paddr_i == ussl_pkg::USSL_RXDATA_OFS) & ~empty;
  assign push = rx_done & (~full | pop);
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || !port_en) begin
      fcnt_r <= '0;
      rptr_r <= '0;
      wptr_r <= '0;
    end else begin
      if (push) begin
        fifo_r[wptr_r].data <= rx_word;
        wptr_r <= (wptr_r == ($clog2(RX_DEPTH))'(RX_DEPTH - 1)) ? '0 :
                  wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= (rptr_r == ($clog2(RX_DEPTH))'(RX_DEPTH - 1)) ? '0 :
                  rptr_r + 1'b1;
      end
      fcnt_r <= fcnt_r + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    end
  end
  logic rx_flag;
  assign rx_flag = ~empty;
  logic overrun;
  assign overrun = rx_done & full & ~pop;

  // Transmit: buffer plus shifter, shift out on falling clock edge
  ussl_pkg::ussl_tx_state_t tst_r;
  logic [8:0] tx_sh_r;
  logic [3:0] tcnt_r;
  logic [8:0] tbuf_r;
  logic tbuf_full_r;
  logic dout_r;
  logic tx_wr;
  logic [3:0] tbits;
  logic tx_last;
  assign tx_wr = wr_en & (paddr_i == ussl_pkg::USSL_TXDATA_OFS);
  assign tbits = ts_r[ussl_pkg::USSL_TS_TX9] ? ussl_pkg::USSL_BITS9 :
                 ussl_pkg::USSL_BITS8;
  assign tx_last = (tst_r == ussl_pkg::USSL_SHIFT) & ck_fall &
                   (tcnt_r == tbits - 4'h1);
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || !port_en) begin
      tst_r <= ussl_pkg::USSL_IDLE;
      tx_sh_r <= 9'h000;
      tcnt_r <= 4'h0;
      tbuf_r <= 9'h000;
      tbuf_full_r <= 1'b0;
      dout_r <= 1'b0;
    end else begin
      if (tx_wr) begin
        tbuf_r <= {ts_r[ussl_pkg::USSL_TS_TX9D], pwdata_i[7:0]};
        tbuf_full_r <= 1'b1;
      end
      case (tst_r)
        ussl_pkg::USSL_IDLE: begin
          if (tx_mode && tbuf_full_r && !tx_wr) begin
            tx_sh_r <= tbuf_r;
            tbuf_full_r <= 1'b0;
            tcnt_r <= 4'h0;
            dout_r <= tbuf_r[0];
            tst_r <= ussl_pkg::USSL_SHIFT;
          end
        end
        ussl_pkg::USSL_SHIFT: begin
          if (!tx_mode) begin
            tst_r <= ussl_pkg::USSL_IDLE;
          end else if (ck_fall) begin
            if (tx_last) begin
              // Pending byte moves straight into the shifter
              if (tbuf_full_r && !tx_wr) begin
                tx_sh_r <= tbuf_r;
                tbuf_full_r <= 1'b0;
                tcnt_r <= 4'h0;
                dout_r <= tbuf_r[0];
              end else begin
                tst_r <= ussl_pkg::USSL_IDLE;
              end
            end else begin
              tx_sh_r <= {1'b0, tx_sh_r[8:1]};
              dout_r <= tx_sh_r[1];
              tcnt_r <= tcnt_r + 4'h1;
            end
          end
        end
        default: tst_r <= ussl_pkg::USSL_IDLE;
      endcase
    end
  end
  logic tx_flag;
  assign tx_flag = ~tbuf_full_r;
  logic trmt;
  assign trmt = (tst_r == ussl_pkg::USSL_IDLE);

  // Overrun latch, cleared only by continuous receive or port going low
  logic oerr_r;
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || !port_en || !cont_rx) begin
      oerr_r <= 1'b0;
    end else if (overrun) begin
      oerr_r <= 1'b1;
    end
  end

  // Control registers
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rs_r <= ussl_pkg::USSL_RS_RESET;
      ts_r <= ussl_pkg::USSL_TS_RESET;
      baud_r <= 8'h00;
      divlo_r <= 8'h00;
      divhi_r <= 8'h00;
      imask_r <= 3'h0;
      core_r <= 3'h0;
    end else if (wr_en) begin
      if (paddr_i == ussl_pkg::USSL_RXSTAT_OFS) begin
        rs_r <= {pwdata_i[7:2], 2'b00};
      end else if (paddr_i == ussl_pkg::USSL_TXSTAT_OFS) begin
        ts_r <= {pwdata_i[7:2], 1'b0, pwdata_i[0]};
      end else if (paddr_i == ussl_pkg::USSL_BAUD_OFS) begin
        baud_r <= {3'h0, pwdata_i[4:3], 1'b0, pwdata_i[1:0]};
      end else if (paddr_i == ussl_pkg::USSL_DIVLO_OFS) begin
        divlo_r <= pwdata_i[7:0];
      end else if (paddr_i == ussl_pkg::USSL_DIVHI_OFS) begin
        divhi_r <= pwdata_i[7:0];
      end else if (paddr_i == ussl_pkg::USSL_IRQMASK_OFS) begin
        imask_r <= pwdata_i[2:0];
      end else if (paddr_i == ussl_pkg::USSL_CORECTL_OFS) begin
        core_r <= pwdata_i[2:0];
      end
    end
  end

  // Sticky status: event set wins over a write-one clear
  logic [2:0] ev;
  logic [2:0] wclr;
  assign ev = {overrun, tx_last & tbuf_full_r, push};
  assign wclr = (wr_en && paddr_i == ussl_pkg::USSL_IRQSTAT_OFS) ?
                pwdata_i[2:0] : 3'h0;
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ists_r <= 3'h0;
    end else begin
      ists_r <= (ists_r & ~wclr) | ev;
    end
  end

  // Level flags gated by enables; sleep shifting needs no system clock gate
  logic pend;
  assign pend = (rx_flag & imask_r[ussl_pkg::USSL_IRQ_RC]) |
                (tx_flag & port_en & ts_r[ussl_pkg::USSL_TS_TXEN] &
                 imask_r[ussl_pkg::USSL_IRQ_TX]) |
                (ists_r[ussl_pkg::USSL_IRQ_OV] &
                 imask_r[ussl_pkg::USSL_IRQ_OV]);
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
      wake_o <= 1'b0;
      vector_o <= 1'b0;
    end else begin
      irq_o <= pend;
      // Only slave mode runs while asleep, so only it can wake
      wake_o <= pend & core_r[ussl_pkg::USSL_CC_PERIEN] &
                core_r[ussl_pkg::USSL_CC_SLEEP] & slave;
      vector_o <= pend & core_r[ussl_pkg::USSL_CC_PERIEN] &
                  core_r[ussl_pkg::USSL_CC_GLOBEN];
    end
  end

  // Data pin driven only while transmitting in slave mode
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      serial_data_pin_o <= 1'b0;
      serial_data_pin_oe_o <= 1'b0;
    end else begin
      serial_data_pin_o <= dout_r;
      serial_data_pin_oe_o <= tx_mode;
    end
  end

  // APB read path, zero wait states
  logic [7:0] rdat;
  always_comb begin
    rdat = 8'h00;
    if (paddr_i == ussl_pkg::USSL_RXSTAT_OFS) begin
      rdat = {rs_r[7:2], oerr_r, fifo_r[rptr_r].data[8] & ~empty};
    end else if (paddr_i == ussl_pkg::USSL_TXSTAT_OFS) begin
      rdat = {ts_r[7:2], trmt, ts_r[0]};
    end else if (paddr_i == ussl_pkg::USSL_RXDATA_OFS) begin
      rdat = empty ? 8'h00 : fifo_r[rptr_r].data[7:0];
    end else if (paddr_i == ussl_pkg::USSL_BAUD_OFS) begin
      rdat = {baud_r[7], trmt & ~rx_mode, baud_r[5:0]};
    end else if (paddr_i == ussl_pkg::USSL_DIVLO_OFS) begin
      rdat = divlo_r;
    end else if (paddr_i == ussl_pkg::USSL_DIVHI_OFS) begin
      rdat = divhi_r;
    end else if (paddr_i == ussl_pkg::USSL_IRQSTAT_OFS) begin
      rdat = {3'h0, tx_flag, rx_flag, ists_r};
    end else if (paddr_i == ussl_pkg::USSL_IRQMASK_OFS) begin
      rdat = {5'h00, imask_r};
    end else if (paddr_i == ussl_pkg::USSL_CORECTL_OFS) begin
      rdat = {5'h00, core_r};
    end
  end
  logic unmapped;
  assign unmapped = (paddr_i > ussl_pkg::USSL_CORECTL_OFS) ||
                    (paddr_i[1:0] != 2'b00) ||
                    (pwrite_i && paddr_i == ussl_pkg::USSL_RXDATA_OFS);
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
      prdata_o <= {24'h00_0000, rdat};
      pslverr_o <= psel_i & ~penable_i & unmapped;
    end
  end
endmodule : ussl_top
